// ===== verilog/dcslm_pkg.sv
// Shared constants and types of the dual clock serial line memory
package dcslm_pkg;

    // ------------------------------------------------------------
    // Storage geometry
    // ------------------------------------------------------------
    localparam int DCSLM_DEPTH = 5048;
    localparam int DCSLM_AW = 13;
    localparam int DCSLM_DW = 8;

    typedef logic [DCSLM_AW-1:0] dcslm_ptr_t;
    typedef logic [DCSLM_DW-1:0] dcslm_word_t;

    // Location 5047 is the last one; 5048 words in all
    localparam dcslm_ptr_t DCSLM_LAST_LOC = 13'h13b7;
    localparam dcslm_ptr_t DCSLM_FIRST_LOC = 13'h0000;
    localparam dcslm_ptr_t DCSLM_PTR_STEP = 13'h0001;

    // ------------------------------------------------------------
    // Pass length and initialisation counting
    // ------------------------------------------------------------
    typedef logic [4:0] dcslm_cnt_t;
    localparam dcslm_cnt_t DCSLM_MIN_PASS = 5'h12;
    localparam dcslm_cnt_t DCSLM_CNT_RST = 5'h00;
    localparam dcslm_cnt_t DCSLM_CNT_STEP = 5'h01;

    // ------------------------------------------------------------
    // Delay and pointer distance limits kept by the driving logic
    // ------------------------------------------------------------
    localparam int DCSLM_MIN_DELAY = 40;
    localparam int DCSLM_MAX_DELAY = 5048;
    localparam int DCSLM_MIN_PTR_GAP = 40;
    localparam int DCSLM_RETAIN_MS = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam dcslm_word_t DCSLM_DATA_RST = 8'h00;
    localparam logic DCSLM_OE_N_RST = 1'b1;

    // Widths of the synchronised pin groups
    localparam int DCSLM_WR_PINS = 11;
    localparam int DCSLM_RD_PINS = 3;

endpackage

// ===== verilog/dcslm_sync.sv
// Two-stage synchroniser for a group of pin inputs
module dcslm_sync
    import dcslm_pkg::*;
#(
    parameter int W = 1
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } dcslm_sync_s;

    dcslm_sync_s st_reg;
    dcslm_sync_s st_next;

    // ------------------------------------------------------------
    // Next state: first stage feeds only the second
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.s1 = pin_in;
        st_next.s2 = st_reg.s1;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign pin_out = st_reg.s2;

endmodule

// ===== verilog/dcslm_ptr.sv
// Sequential address pointer with clear and wrap
module dcslm_ptr
    import dcslm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic step_in,
    input wire logic clear_in,
    output dcslm_ptr_t ptr_out,
    output logic wrap_out
);

    typedef struct packed {
        dcslm_ptr_t ptr;
        logic wrap;
    } dcslm_ptr_s;

    dcslm_ptr_s st_reg;
    dcslm_ptr_s st_next;

    // ------------------------------------------------------------
    // Clear beats step; last location wraps to the first
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.wrap = 1'b0;
        if (clear_in) begin
            st_next.ptr = DCSLM_FIRST_LOC; // RQ23
        end else if (step_in) begin
            if (st_reg.ptr == DCSLM_LAST_LOC) begin
                st_next.ptr = DCSLM_FIRST_LOC; // RQ23
                st_next.wrap = 1'b1;
            end else begin
                st_next.ptr = st_reg.ptr + DCSLM_PTR_STEP; // RQ23
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ptr_out = st_reg.ptr;
    assign wrap_out = st_reg.wrap;

endmodule

// ===== verilog/dcslm_top.sv
// Dual clock serial line memory: 5048 words of 8 bits as a delay line
//
// Requirements
// RQ1: Store input word on gated write edge
// RQ2: Present next stored word per gated read edge
// RQ3: Write clear zeroes write pointer next edge
// RQ4: Write pointer wraps after last location
// RQ5: Read clear zeroes read pointer next edge
// RQ6: Read pointer wraps after last location
// RQ7: Source gives 18 write cycles per pass
// RQ8: Sink gives 18 read cycles per pass
// RQ9: Write gate high: no store, pointer held
// RQ10: Read gate high: hold pointer, float output
// RQ11: Read gate low: drivers back next edge
// RQ12: Gated write edge advances write pointer
// RQ13: Gated read edge outputs word, advances pointer
// RQ14: Driver keeps pointers over 40 apart
// RQ15: Read each word within 10 ms
// RQ16: Delays 40 to 5048 words supported
// RQ17: Clear write pointer after pass ends
// RQ18: Pointers cleared before use; write starts at 0
// RQ19: Wait 100 us after power before init
// RQ20: 18 dummy cycles then clear, per port
// RQ21: Early start: clear, 18 cycles, clear
// RQ22: Clear acts on sampled edge alone
// RQ23: 13-bit pointer, wrap, clear beats step
module dcslm_top
    import dcslm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic wr_side_clk_in,
    input wire logic wr_side_gate_n_in,
    input wire logic wr_ptr_clear_n_in,
    input wire logic [DCSLM_DW-1:0] wr_data_in,
    input wire logic out_side_clk_in,
    input wire logic out_side_gate_n_in,
    input wire logic out_ptr_clear_n_in,
    output logic [DCSLM_DW-1:0] out_data_out,
    output logic out_data_oe_n_out,
    output logic [DCSLM_AW-1:0] wr_addr_out,
    output logic [DCSLM_AW-1:0] out_addr_out,
    output logic wr_wrap_out,
    output logic out_wrap_out,
    output logic wr_ready_out,
    output logic out_ready_out
);

    // ------------------------------------------------------------
    // Block state
    // ------------------------------------------------------------
    typedef struct packed {
        logic wr_clk_prev;
        logic out_clk_prev;
        dcslm_word_t out_word;
        logic out_oe_n;
        dcslm_cnt_t wr_cnt;
        dcslm_cnt_t out_cnt;
        logic wr_ready;
        logic out_ready;
    } dcslm_top_s;

    dcslm_top_s st_reg;
    dcslm_top_s st_next;

    // Line storage, one word per location
    dcslm_word_t mem_arr [DCSLM_DEPTH];

    // Synchronised pins
    logic [DCSLM_WR_PINS-1:0] wr_pins_s;
    logic [DCSLM_RD_PINS-1:0] out_pins_s;
    logic wr_clk_s;
    logic wr_gate_n_s;
    logic wr_clear_n_s;
    dcslm_word_t wr_data_s;
    logic out_clk_s;
    logic out_gate_n_s;
    logic out_clear_n_s;

    // Per-edge decisions
    logic wr_edge;
    logic out_edge;
    logic wr_clear;
    logic out_clear;
    logic wr_store;
    logic out_step;
    dcslm_ptr_t wr_ptr;
    dcslm_ptr_t out_ptr;
    logic wr_wrap;
    logic out_wrap;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // The port clocks are plain pins sampled on mclk_in. Data and
    // controls pass through the same two stages as their clock, so
    // the values seen at a detected edge match those at the pin edge.
    dcslm_sync #(
        .W(DCSLM_WR_PINS)
    ) u_wr_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in({wr_side_clk_in, wr_side_gate_n_in, wr_ptr_clear_n_in,
                 wr_data_in}),
        .pin_out(wr_pins_s)
    );

    dcslm_sync #(
        .W(DCSLM_RD_PINS)
    ) u_out_sync (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .pin_in({out_side_clk_in, out_side_gate_n_in, out_ptr_clear_n_in}),
        .pin_out(out_pins_s)
    );

    assign {wr_clk_s, wr_gate_n_s, wr_clear_n_s, wr_data_s} = wr_pins_s;
    assign {out_clk_s, out_gate_n_s, out_clear_n_s} = out_pins_s;

    // ------------------------------------------------------------
    // Edge detection and gating
    // ------------------------------------------------------------
    assign wr_edge = wr_clk_s & ~st_reg.wr_clk_prev;
    assign out_edge = out_clk_s & ~st_reg.out_clk_prev;

    // A clear needs only the sampled level at one edge
    assign wr_clear = wr_edge & ~wr_clear_n_s; // RQ3 RQ22
    assign out_clear = out_edge & ~out_clear_n_s; // RQ5 RQ22

    // Gate high at an edge stores nothing and holds the pointer
    assign wr_store = wr_edge & ~wr_gate_n_s & wr_clear_n_s; // RQ1 RQ9
    assign out_step = out_edge & ~out_gate_n_s & out_clear_n_s; // RQ13 RQ10

    // ------------------------------------------------------------
    // Address pointers
    // ------------------------------------------------------------
    dcslm_ptr u_wr_ptr (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .step_in(wr_store), // RQ12 RQ4
        .clear_in(wr_clear), // RQ3 RQ18
        .ptr_out(wr_ptr),
        .wrap_out(wr_wrap)
    );

    dcslm_ptr u_out_ptr (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .step_in(out_step), // RQ13 RQ6
        .clear_in(out_clear), // RQ5 RQ18
        .ptr_out(out_ptr),
        .wrap_out(out_wrap)
    );

    // ------------------------------------------------------------
    // Storage array
    // ------------------------------------------------------------
    // Any location may serve as the delay tap, so any delay from
    // the minimum gap up to the full line is reachable.
    always_ff @(posedge mclk_in) begin
        if (wr_store) begin
            mem_arr[wr_ptr] <= wr_data_s; // RQ1 RQ16
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.wr_clk_prev = wr_clk_s;
        st_next.out_clk_prev = out_clk_s;

        // Read side output word and drivers
        if (out_edge) begin
            if (out_gate_n_s) begin
                st_next.out_oe_n = 1'b1; // RQ10
            end else begin
                st_next.out_oe_n = 1'b0; // RQ11
                if (out_clear_n_s) begin
                    st_next.out_word = mem_arr[out_ptr]; // RQ2 RQ13
                end
            end
        end

        // Write side initialisation tracking
        if (wr_edge) begin
            if (!wr_clear_n_s) begin
                if (st_reg.wr_cnt >= DCSLM_MIN_PASS) begin
                    st_next.wr_ready = 1'b1; // RQ20 RQ21
                end
                st_next.wr_cnt = DCSLM_CNT_RST;
            end else if (st_reg.wr_cnt < DCSLM_MIN_PASS) begin
                st_next.wr_cnt = st_reg.wr_cnt + DCSLM_CNT_STEP;
            end
        end

        // Read side initialisation tracking
        if (out_edge) begin
            if (!out_clear_n_s) begin
                if (st_reg.out_cnt >= DCSLM_MIN_PASS) begin
                    st_next.out_ready = 1'b1; // RQ20 RQ21
                end
                st_next.out_cnt = DCSLM_CNT_RST;
            end else if (st_reg.out_cnt < DCSLM_MIN_PASS) begin
                st_next.out_cnt = st_reg.out_cnt + DCSLM_CNT_STEP;
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st_reg.wr_clk_prev <= 1'b0;
            st_reg.out_clk_prev <= 1'b0;
            st_reg.out_word <= DCSLM_DATA_RST;
            st_reg.out_oe_n <= DCSLM_OE_N_RST;
            st_reg.wr_cnt <= DCSLM_CNT_RST;
            st_reg.out_cnt <= DCSLM_CNT_RST;
            st_reg.wr_ready <= 1'b0;
            st_reg.out_ready <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign out_data_out = st_reg.out_word;
    assign out_data_oe_n_out = st_reg.out_oe_n;
    assign wr_addr_out = wr_ptr;
    assign out_addr_out = out_ptr;
    assign wr_wrap_out = wr_wrap;
    assign out_wrap_out = out_wrap;
    assign wr_ready_out = st_reg.wr_ready;
    assign out_ready_out = st_reg.out_ready;

endmodule

// ===== tb/dcslm_chk.sv
// Assertions on the ports of the serial line memory
module dcslm_chk
    import dcslm_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic wr_side_clk_in,
    input wire logic wr_side_gate_n_in,
    input wire logic wr_ptr_clear_n_in,
    input wire logic out_side_clk_in,
    input wire logic out_side_gate_n_in,
    input wire logic out_ptr_clear_n_in,
    input wire logic [DCSLM_DW-1:0] out_data_out,
    input wire logic out_data_oe_n_out,
    input wire logic [DCSLM_AW-1:0] wr_addr_out,
    input wire logic [DCSLM_AW-1:0] out_addr_out,
    input wire logic wr_wrap_out
);
    logic [3:0] wsh_reg;
    logic [3:0] rsh_reg;

    function automatic dcslm_ptr_t nxt(dcslm_ptr_t p);
        return (p == DCSLM_LAST_LOC) ? DCSLM_FIRST_LOC : p + DCSLM_PTR_STEP;
    endfunction

    // Pin history: bit 2 set, bit 3 clear marks a rise seen 3 edges ago
    always_ff @(posedge mclk_in) begin
        wsh_reg <= {wsh_reg[2:0], wr_side_clk_in};
        rsh_reg <= {rsh_reg[2:0], out_side_clk_in};
    end

    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    AST_WR_STEP: assert property (
        $rose(wr_side_clk_in) && !wr_side_gate_n_in && wr_ptr_clear_n_in
        |-> ##3 wr_addr_out == nxt($past(wr_addr_out, 3)))
        else $error("write pointer did not step");
    AST_WR_HOLD: assert property (
        $rose(wr_side_clk_in) && wr_side_gate_n_in && wr_ptr_clear_n_in
        |-> ##3 wr_addr_out == $past(wr_addr_out, 3))
        else $error("write pointer moved with gate high");
    AST_WR_CLEAR: assert property (
        $rose(wr_side_clk_in) && !wr_ptr_clear_n_in
        |-> ##3 wr_addr_out == DCSLM_FIRST_LOC)
        else $error("write pointer not cleared");
    AST_WR_WRAP: assert property (
        wr_wrap_out |-> wr_addr_out == DCSLM_FIRST_LOC
        && $past(wr_addr_out) == DCSLM_LAST_LOC)
        else $error("write wrap pulse without wrap");
    AST_WR_STAND: assert property (
        $changed(wr_addr_out) |-> wsh_reg[2] && !wsh_reg[3])
        else $error("write pointer changed without port edge");
    AST_RD_STEP: assert property (
        $rose(out_side_clk_in) && !out_side_gate_n_in && out_ptr_clear_n_in
        |-> ##3 out_addr_out == nxt($past(out_addr_out, 3))
        && !out_data_oe_n_out)
        else $error("read pointer did not step");
    AST_RD_OFF: assert property (
        $rose(out_side_clk_in) && out_side_gate_n_in && out_ptr_clear_n_in
        |-> ##3 out_data_oe_n_out && out_addr_out == $past(out_addr_out, 3))
        else $error("read port not suspended");
    AST_RD_CLEAR: assert property (
        $rose(out_side_clk_in) && !out_ptr_clear_n_in && !out_side_gate_n_in
        |-> ##3 out_addr_out == DCSLM_FIRST_LOC)
        else $error("read pointer not cleared");
    AST_RD_STAND: assert property (
        $changed(out_data_out) || $changed(out_data_oe_n_out)
        |-> rsh_reg[2] && !rsh_reg[3])
        else $error("read output changed without port edge");
endmodule

bind dcslm_top dcslm_chk u_chk (.*);

// ===== tb/dcslm_drv.sv
// Streaming logic model driving one port of the line memory
module dcslm_drv
    import dcslm_pkg::*;
(
    input wire logic mclk_in,
    output logic side_clk_out,
    output logic gate_n_out,
    output logic clear_n_out,
    output dcslm_word_t data_out
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        side_clk_out = 1'b0;
        gate_n_out = 1'b1;
        clear_n_out = 1'b1;
        data_out = 8'h00;
    end

    // One port cycle; the port clock stays low between cycles
    task automatic cycle(input logic g_n, input logic c_n, input dcslm_word_t d);
        @(posedge mclk_in);
        gate_n_out <= g_n;
        clear_n_out <= c_n;
        data_out <= g_n ? ~data_out : d;
        @(posedge mclk_in);
        side_clk_out <= 1'b1;
        repeat (4) @(posedge mclk_in);
        side_clk_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule

// ===== tb/dual_clock_serial_line_memory_bench.sv
// Self-checking bench of the serial line memory
module dual_clock_serial_line_memory_bench
    import dcslm_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 100ps;

    typedef struct packed {
        logic rd;
        logic g_n;
        logic c_n;
        logic [7:0] d;
        logic [12:0] addr;
        logic oe_n;
    } dcslm_row_s;

    logic mclk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic wr_side_clk_in, wr_side_gate_n_in, wr_ptr_clear_n_in;
    logic out_side_clk_in, out_side_gate_n_in, out_ptr_clear_n_in;
    logic [7:0] wr_data_in, out_data_out;
    logic [12:0] wr_addr_out, out_addr_out;
    logic out_data_oe_n_out, wr_wrap_out, out_wrap_out;
    logic wr_ready_out, out_ready_out;
    int n_mismatch = 0;
    int samples_checked = 0;
    int n_wrap_wr = 0;
    int n_wrap_rd = 0;
    // Write rows: d is stored data; read rows: d is expected output
    dcslm_row_s rows [11] = '{
        '{0, 0, 1, 8'ha1, 13'h1, 1}, '{0, 0, 1, 8'hb2, 13'h2, 1},
        '{0, 1, 1, 8'hff, 13'h2, 1}, '{0, 0, 1, 8'hc3, 13'h3, 1},
        '{1, 0, 1, 8'ha1, 13'h1, 0}, '{1, 1, 1, 8'ha1, 13'h1, 1},
        '{1, 0, 1, 8'hb2, 13'h2, 0}, '{1, 0, 1, 8'hc3, 13'h3, 0},
        '{0, 0, 0, 8'h55, 13'h0, 1}, '{1, 0, 0, 8'hc3, 13'h0, 0},
        '{1, 0, 1, 8'ha1, 13'h1, 0}};

    always #2.5 mclk_in = ~mclk_in;

    dcslm_top DUT (.*);
    dcslm_drv u_wr (.mclk_in, .side_clk_out(wr_side_clk_in),
        .gate_n_out(wr_side_gate_n_in), .clear_n_out(wr_ptr_clear_n_in),
        .data_out(wr_data_in));
    dcslm_drv u_rd (.mclk_in, .side_clk_out(out_side_clk_in),
        .gate_n_out(out_side_gate_n_in), .clear_n_out(out_ptr_clear_n_in),
        .data_out());

    always @(posedge mclk_in) begin
        if (wr_wrap_out === 1'b1) n_wrap_wr++;
        if (out_wrap_out === 1'b1) n_wrap_rd++;
    end

    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        #450_000;
        n_mismatch++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        // Supplies settle for 100 us before the ports are touched
        repeat (20000) @(posedge mclk_in);
        // ------------------------------------------------------------
        // Initialisation: 18 moving cycles, then a clear, both ports
        // ------------------------------------------------------------
        fork
            begin
                repeat (18) u_wr.cycle(1'b0, 1'b1, 8'h00);
                u_wr.cycle(1'b0, 1'b0, 8'h00);
            end
            begin
                repeat (18) u_rd.cycle(1'b0, 1'b1, 8'h00);
                u_rd.cycle(1'b0, 1'b0, 8'h00);
            end
        join
        #1;
        chk(wr_addr_out, 13'h0000);
        chk(out_addr_out, 13'h0000);
        chk({11'h0, wr_ready_out, out_ready_out}, 13'h0003);
        $display("test init done");
        foreach (rows[i]) begin
            if (rows[i].rd) begin
                u_rd.cycle(rows[i].g_n, rows[i].c_n, 8'h00);
                #1;
                chk(out_addr_out, rows[i].addr);
                chk({5'h0, out_data_out}, {5'h0, rows[i].d});
                chk({12'h0, out_data_oe_n_out}, {12'h0, rows[i].oe_n});
            end else begin
                u_wr.cycle(rows[i].g_n, rows[i].c_n, rows[i].d);
                #1;
                chk(wr_addr_out, rows[i].addr);
            end
        end
        $display("test rows done");
        // ------------------------------------------------------------
        // Full pass on both ports with a 48 word lag, wrap on each
        // ------------------------------------------------------------
        u_rd.cycle(1'b0, 1'b0, 8'h00);
        n_wrap_wr = 0;
        n_wrap_rd = 0;
        fork
            for (int i = 0; i < DCSLM_DEPTH; i++)
                u_wr.cycle(1'b0, 1'b1, 8'(i ^ 8'h5a));
            begin
                repeat (48 * 10) @(posedge mclk_in);
                for (int i = 0; i < DCSLM_DEPTH; i++) begin
                    u_rd.cycle(1'b0, 1'b1, 8'h00);
                    #1;
                    chk({5'h0, out_data_out}, {5'h0, 8'(i ^ 8'h5a)});
                end
            end
        join
        #1;
        chk(wr_addr_out, 13'h0000);
        chk(out_addr_out, 13'h0000);
        chk(13'(n_wrap_wr * 2 + n_wrap_rd), 13'h0003);
        u_wr.cycle(1'b0, 1'b0, 8'h00);
        $display("test wrap done");
        // Reset in mid-run after both pointers have moved
        u_wr.cycle(1'b0, 1'b1, 8'h11);
        u_rd.cycle(1'b0, 1'b1, 8'h00);
        rst_b_in <= 1'b0;
        repeat (20) @(posedge mclk_in);
        #1;
        chk(wr_addr_out | out_addr_out, 13'h0000);
        chk({out_data_out, out_data_oe_n_out, wr_ready_out, out_ready_out,
            wr_wrap_out, out_wrap_out}, 13'h0010);
        $display("test reset done");
        // Early start recovery: clear, 18 gated-off cycles, clear
        rst_b_in <= 1'b1;
        repeat (4) @(posedge mclk_in);
        fork
            begin
                u_wr.cycle(1'b0, 1'b0, 8'h00);
                repeat (18) u_wr.cycle(1'b1, 1'b1, 8'h00);
                u_wr.cycle(1'b0, 1'b0, 8'h00);
            end
            begin
                u_rd.cycle(1'b0, 1'b0, 8'h00);
                repeat (18) u_rd.cycle(1'b1, 1'b1, 8'h00);
                u_rd.cycle(1'b0, 1'b0, 8'h00);
            end
        join
        #1;
        chk(wr_addr_out | out_addr_out, 13'h0000);
        chk({11'h0, wr_ready_out, out_ready_out}, 13'h0003);
        $display("test early init done");
        tally_and_finish();
    end
endmodule
